// ===== hw/ebc_defines.vh
// Constants for the external bus control block
`ifndef EBC_DEFINES_VH
`define EBC_DEFINES_VH
`define EBC_AW          32
`define EBC_DW          64
`define EBC_HW          32
`define EBC_BANK_HI     31
`define EBC_BANK_LO     26
`define EBC_BANK0_CODE  6'h02
`define EBC_BANK1_CODE  6'h03
`define EBC_HOST_HI     31
`define EBC_HOST_LO     28
`define EBC_HOST_NONE   4'h0
`define EBC_ADDR_STEP   32'h0000_0001
`define EBC_ST_IDLE     2'h0
`define EBC_ST_ADDR     2'h1
`define EBC_ST_DATA     2'h2
`define EBC_ST_DONE     2'h3
`endif

// ===== hw/ebc_external_bus_control.v
// External bus port control: master strobes, slave decode, boot select
// Notes on behaviour
// (RULE1) As master drive the address lines; as slave take them as inputs.
// (RULE2) Data bus is 64 bits, two-way, carrying data and instructions.
// (RULE3) Read strobe asserts on every master read except synchronous DRAM.
// (RULE4) As slave, sampled read strobe marks reads of internal memory.
// (RULE5) Read, write strobes and selects change on the address edge.
// (RULE6) Low write strobe for even words and for any 32-bit zone write.
// (RULE7) External master asserts low strobe to write our low word.
// (RULE8) High write strobe for long words or odd words on 64-bit bus.
// (RULE9) External master asserts high strobe to write our high word.
// (RULE10) As slave, both write strobes mark writes to internal memory.
// (RULE11) External slave may hold acknowledge low to add wait states.
// (RULE12) Device may hold acknowledge low while being read as slave.
// (RULE13) Acknowledge left undriven during slave writes; pull-up holds it.
// (RULE14) Boot select is a strap at reset, then boot chip select.
// (RULE15) Bank 0 select on address 31:26 = 000010, bank 1 on 000011.
// (RULE16) Host select whenever address bits 31:28 are not all zero.
// (RULE17) Only the current bus master drives host select and strobes.
// (RULE18) Master flags consecutive transfers; slave may count addresses.
// (RULE19) In host bursts the slave address advances while flag holds.
`include "ebc_defines.vh"
module ebc_external_bus_control (
    // Clock and reset
    input  wire                clk,
    input  wire                rst_n,
    // Mastership and boot
    input  wire                bus_master,
    input  wire                boot_active,
    // Master request from core (32-bit wide zone, sdram target)
    input  wire                req_valid,
    output reg                 req_ready,
    input  wire                req_write,
    input  wire                req_long,
    input  wire                req_zone32,
    input  wire                req_sdram,
    input  wire                req_burst,
    input  wire [31:0]         req_addr,
    input  wire [63:0]         req_wdata,
    output reg                 rsp_valid,
    output reg  [63:0]         rsp_rdata,
    // Slave side towards internal memory (buffered)
    output reg                 slv_valid,
    input  wire                slv_ready,
    output reg                 slv_write,
    output reg  [1:0]          slv_lanes,
    output reg  [31:0]         slv_addr,
    output reg  [63:0]         slv_wdata,
    input  wire                slv_rdata_valid,
    input  wire [63:0]         slv_rdata,
    // Address lines
    input  wire [31:0]         ext_address_lines_in,
    output reg  [31:0]         ext_address_lines_out,
    output reg                 ext_address_lines_oe,
    // Data lines
    input  wire [63:0]         ext_data_lines_in,
    output reg  [63:0]         ext_data_lines_out,
    output reg                 ext_data_lines_oe,
    // Strobes, active low, three signals each
    input  wire                read_n_in,
    output reg                 read_n_out,
    input  wire                low_word_write_n_in,
    output reg                 low_word_write_n_out,
    input  wire                high_word_write_n_in,
    output reg                 high_word_write_n_out,
    output reg                 strobe_oe,
    input  wire                consecutive_transfer_n_in,
    output reg                 consecutive_transfer_n_out,
    // Acknowledge (open drain, driven low only)
    input  wire                ack_in,
    output reg                 ack_out,
    output reg                 ack_oe,
    // Decoded selects
    output reg  [1:0]          bank_select_n,
    output reg                 host_space_select_n,
    output reg                 select_oe,
    // Boot memory select, strap during reset
    input  wire                boot_memory_select_n_in,
    output reg                 boot_memory_select_n_out,
    output reg                 boot_memory_select_n_oe,
    output reg                 eprom_boot_strap
);

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    // Master access being worked on
    reg         cur_write;
    reg         cur_long;
    reg         cur_zone32;
    reg         cur_sdram;
    reg  [31:0] cur_addr;
    reg  [63:0] cur_wdata;
    // Slave side burst counter and read bookkeeping
    reg  [31:0] slv_count;
    reg         slv_burst;
    reg         rd_pending;
    reg         strap_taken;
    // Two-entry buffer towards internal memory
    reg  [98:0] buf_mem [0:1];
    reg         buf_wr;
    reg         buf_rd;
    reg  [1:0]  buf_cnt;
    reg  [98:0] buf_in;
    reg         push;
    reg  [31:0] slave_addr;
    wire        buf_full  = (buf_cnt == 2'h2);
    wire        buf_empty = (buf_cnt == 2'h0);
    wire        pop       = slv_valid && slv_ready;
    // Slave strobes only count while another agent owns the bus
    wire        slv_rd    = !bus_master && !read_n_in;            // see (RULE4)
    wire        slv_wl    = !bus_master && !low_word_write_n_in;  // see (RULE10)
    wire        slv_wh    = !bus_master && !high_word_write_n_in; // see (RULE10)
    wire        slv_any   = slv_rd || slv_wl || slv_wh;
    // Request taken on this edge; the core holds it until then
    wire        go        = req_valid && req_ready;
    // Strobe values for a new master access
    wire        m_rd      = go && !req_write && !req_sdram;       // see (RULE3)
    wire        m_wl      = go && req_write &&
                            (req_zone32 || req_long || !req_addr[0]); // see (RULE6)
    wire        m_wh      = go && req_write && !req_zone32 &&
                            (req_long || req_addr[0]);          // see (RULE8)

    // Master sequencing state
    always @* begin
        next_state = state;
        case (state)
            `EBC_ST_IDLE: if (go) next_state = `EBC_ST_DATA;
            `EBC_ST_DATA: if (ack_in) next_state = `EBC_ST_DONE; // see (RULE11)
            // One quiet cycle lets the strobes rise before the next access
            `EBC_ST_DONE: next_state = `EBC_ST_IDLE;
            default:      next_state = `EBC_ST_IDLE;
        endcase
    end

    // Slave address: first from the lines, then from the burst counter
    always @* begin
        slave_addr = (slv_burst && !consecutive_transfer_n_in) ?
                     slv_count : ext_address_lines_in;          // see (RULE18)
        // Entry: write flag, high and low lane, address, data
        buf_in = {!slv_rd, slv_wh, slv_wl,
                  slave_addr, ext_data_lines_in};
        push = slv_any && !buf_full && !slv_rd;
        if (slv_rd && !rd_pending && !buf_full)
            push = 1'b1;
    end

    // Master side registers; strobes, selects and address share one edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // All drivers off: the pins rest at their pull-ups
            state                      <= `EBC_ST_IDLE;
            cur_write                  <= 1'b0;
            cur_long                   <= 1'b0;
            cur_zone32                 <= 1'b0;
            cur_sdram                  <= 1'b0;
            cur_addr                   <= {`EBC_AW{1'b0}};
            cur_wdata                  <= {`EBC_DW{1'b0}};
            req_ready                  <= 1'b0;
            rsp_valid                  <= 1'b0;
            rsp_rdata                  <= {`EBC_DW{1'b0}};
            ext_address_lines_out      <= {`EBC_AW{1'b0}};
            ext_address_lines_oe       <= 1'b0;
            ext_data_lines_out         <= {`EBC_DW{1'b0}};
            ext_data_lines_oe          <= 1'b0;
            read_n_out                 <= 1'b1;
            low_word_write_n_out       <= 1'b1;
            high_word_write_n_out      <= 1'b1;
            consecutive_transfer_n_out <= 1'b1;
            strobe_oe                  <= 1'b0;
            bank_select_n              <= 2'h3;
            host_space_select_n        <= 1'b1;
            select_oe                  <= 1'b0;
        end else begin
            state     <= next_state;
            rsp_valid <= 1'b0;
            req_ready <= bus_master && (next_state == `EBC_ST_IDLE)
                         && !go;
            // Only the bus master drives address, strobes and selects
            ext_address_lines_oe <= bus_master;              // see (RULE1)
            strobe_oe            <= bus_master;              // see (RULE17)
            select_oe            <= bus_master;              // see (RULE17)
            if (go) begin
                cur_write  <= req_write;
                cur_long   <= req_long;
                cur_zone32 <= req_zone32;
                cur_sdram  <= req_sdram;
                cur_addr   <= req_addr;
                cur_wdata  <= req_wdata;
                ext_address_lines_out <= req_addr;           // see (RULE1)
                read_n_out            <= !m_rd;              // see (RULE5)
                low_word_write_n_out  <= !m_wl;              // see (RULE5)
                high_word_write_n_out <= !m_wh;              // see (RULE5)
                consecutive_transfer_n_out <= !req_burst;    // see (RULE18)
                bank_select_n[0] <= !(req_addr[`EBC_BANK_HI:`EBC_BANK_LO]
                                      == `EBC_BANK0_CODE);   // see (RULE15)
                bank_select_n[1] <= !(req_addr[`EBC_BANK_HI:`EBC_BANK_LO]
                                      == `EBC_BANK1_CODE);   // see (RULE15)
                host_space_select_n <=
                    (req_addr[`EBC_HOST_HI:`EBC_HOST_LO]
                     == `EBC_HOST_NONE);                     // see (RULE16)
                ext_data_lines_out <= req_wdata;             // see (RULE2)
                ext_data_lines_oe  <= req_write;
            end else if (state == `EBC_ST_DATA && ack_in) begin
                // Access ends when the slave stops stretching it
                read_n_out            <= 1'b1;
                low_word_write_n_out  <= 1'b1;
                high_word_write_n_out <= 1'b1;
                consecutive_transfer_n_out <= 1'b1;
                bank_select_n         <= 2'h3;
                host_space_select_n   <= 1'b1;
                ext_data_lines_oe     <= 1'b0;
                // Read data is taken on the edge that ends the access; a
                // write echoes its data so the core sees one answer each
                rsp_valid <= 1'b1;
                rsp_rdata <= cur_write ? cur_wdata : ext_data_lines_in;
            end
            if (!bus_master) begin
                ext_data_lines_oe <= slv_rdata_valid;        // see (RULE2)
                ext_data_lines_out <= slv_rdata;
            end
        end
    end

    // Slave burst counter and acknowledge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slv_count  <= {`EBC_AW{1'b0}};
            slv_burst  <= 1'b0;
            rd_pending <= 1'b0;
            ack_out    <= 1'b0;
            ack_oe     <= 1'b0;
        end else begin
            // The pin is only ever pulled low; the pull-up makes it ready
            ack_out <= 1'b0;
            if (push) begin
                slv_count <= slave_addr + `EBC_ADDR_STEP;    // see (RULE19)
                slv_burst <= !consecutive_transfer_n_in;
            end else if (consecutive_transfer_n_in) begin
                slv_burst <= 1'b0;
            end
            if (push && slv_rd)
                rd_pending <= 1'b1;
            else if (slv_rdata_valid)
                rd_pending <= 1'b0;
            // Wait states only on reads of us; writes leave line to pull-up
            ack_oe <= slv_rd && !slv_rdata_valid; // see (RULE12) (RULE13)
        end
    end

    // Two-entry buffer; a stalled internal memory loses no word until the buffer is full
    // Limitation: writes cannot be stalled on the pins, so a push
    // into a full buffer is lost; internal memory must keep up
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_wr    <= 1'b0;
            buf_rd    <= 1'b0;
            buf_cnt   <= 2'h0;
            slv_valid <= 1'b0;
            slv_write <= 1'b0;
            slv_lanes <= 2'h0;
            slv_addr  <= {`EBC_AW{1'b0}};
            slv_wdata <= {`EBC_DW{1'b0}};
        end else begin
            if (push && !buf_full) begin
                buf_mem[buf_wr] <= buf_in;
                buf_wr <= ~buf_wr;
            end
            if (!slv_valid || slv_ready) begin
                if (!buf_empty) begin
                    // Entry fields line up with the outputs one to one
                    {slv_write, slv_lanes, slv_addr, slv_wdata}
                        <= buf_mem[buf_rd];
                    buf_rd <= ~buf_rd;
                end
                slv_valid <= !buf_empty;
            end
            // Count follows the push and the pop taken on this edge
            buf_cnt <= buf_cnt + {1'b0, push && !buf_full}
                       - {1'b0, (!slv_valid || slv_ready) && !buf_empty};
        end
    end

    // Boot strap caught at release, then boot chip select
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_taken              <= 1'b0;
            eprom_boot_strap         <= 1'b0;
            boot_memory_select_n_out <= 1'b1;
            boot_memory_select_n_oe  <= 1'b0;
        end else begin
            // Read once: later changes of the pin are ignored
            if (!strap_taken) begin
                strap_taken      <= 1'b1;
                eprom_boot_strap <= !boot_memory_select_n_in; // see (RULE14)
            end
            boot_memory_select_n_oe  <= strap_taken && bus_master
                                        && eprom_boot_strap;
            // Boot memory chip select for the whole boot sequence
            boot_memory_select_n_out <= !(eprom_boot_strap && boot_active
                                          && bus_master);     // see (RULE14)
        end
    end

endmodule // ebc_external_bus_control

// ===== dv/ebc_monitor.sv
// Port checker for the external bus control block
module ebc_monitor (
    // Clock, reset and mode
    input wire logic        clk, rst_n, bus_master, boot_active,
    // Master request
    input wire logic        req_valid, req_ready, req_write, req_long,
    input wire logic        req_zone32, req_sdram, req_burst,
    input wire logic [31:0] req_addr, ext_address_lines_out,
    // Pins
    input wire logic        read_n_out, low_word_write_n_out, strobe_oe,
    input wire logic        high_word_write_n_out, ext_address_lines_oe,
    input wire logic [1:0]  bank_select_n,
    input wire logic        host_space_select_n, select_oe, read_n_in,
    input wire logic        low_word_write_n_in, high_word_write_n_in,
    input wire logic        ack_oe, eprom_boot_strap,
    input wire logic        consecutive_transfer_n_out,
    input wire logic        boot_memory_select_n_out, boot_memory_select_n_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Request taken, and the bank field now on the pins
    wire logic       tk = req_valid && req_ready;
    wire logic [5:0] bk = ext_address_lines_out[31:26];
    wire logic       wr = req_write && !req_zone32;
    bank_decode_a: assert property (
        tk |=> bank_select_n == {bk != 6'h03, bk != 6'h02})
        else $error("bank select wrong");
    host_decode_a: assert property (
        tk |=> host_space_select_n == (bk[5:2] == 4'h0))
        else $error("host select wrong");
    same_edge_a: assert property (
        $rose(strobe_oe) |-> $rose(ext_address_lines_oe) && select_oe)
        else $error("strobes not with address");
    master_only_a: assert property (
        !bus_master && !$past(bus_master) |-> !strobe_oe && !select_oe)
        else $error("drive while not master");
    read_strobe_a: assert property (
        tk && !req_write |=> read_n_out == $past(req_sdram))
        else $error("read strobe wrong");
    low_write_a: assert property (
        tk && req_write && (!req_addr[0] || req_zone32 || req_long)
        |=> ##[0:2] !low_word_write_n_out) else $error("low strobe missing");
    high_write_a: assert property (
        tk && wr && (req_addr[0] || req_long) |=> ##[0:2]
        !high_word_write_n_out) else $error("high strobe missing");
    no_high_a: assert property (
        tk && !wr |=> high_word_write_n_out[*3]) else $error("stray high");
    burst_flag_a: assert property (
        tk |=> consecutive_transfer_n_out == !$past(req_burst))
        else $error("burst flag wrong");
    write_ack_a: assert property (
        !bus_master && !(low_word_write_n_in && high_word_write_n_in)
        && read_n_in && $past(read_n_in) |-> !ack_oe)
        else $error("ack driven in write");
    boot_sel_a: assert property (
        boot_active && bus_master && eprom_boot_strap
        && $past(boot_active) && $past(bus_master) |-> boot_memory_select_n_oe
        && !boot_memory_select_n_out) else $error("boot select idle");
    cover property (tk && !req_write);
    cover property (tk && req_write && req_long);
    cover property (ack_oe);
endmodule // ebc_monitor
bind ebc_external_bus_control ebc_monitor ebc_monitor_inst (.*);

// ===== dv/ebc_far_mem.sv
// Far-side memory model: wait states on ack and read data
module ebc_far_mem (
    // Clock and reset
    input wire logic        clk, rst_n,
    // Bus from the device
    input wire logic        strobe_oe, read_n, wr_n,
    input wire logic [31:0] addr,
    input wire logic [3:0]  waits,
    // Answers
    output logic            ack,
    output logic [63:0]     data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0]  cnt;
    logic [63:0] junk;
    wire logic   act = strobe_oe && (!read_n || !wr_n);
    // Count wait states; junk is negated every cycle, so it stays zero from reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            junk <= 64'h0;
        end else begin
            junk <= ~junk + 64'h1;
            cnt <= !act ? 4'h0 : (cnt == waits ? cnt : cnt + 4'h1);
        end
    end
    // Pull-up holds ack ready when idle
    assign ack = !act || cnt == waits;
    // A ready memory shows the word of the address, SDRAM reads included
    assign data = ack ? {~addr, addr} : junk;
endmodule // ebc_far_mem

// ===== dv/ebc_external_bus_control_bench.sv
// Testbench for the external bus control block
module ebc_external_bus_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, bus_master, boot_active, req_valid, req_write, req_long;
    logic req_zone32, req_sdram, req_burst, slv_ready, slv_rdata_valid;
    logic tb_rd_n, tb_wl_n, tb_wh_n, tb_burst_n, tb_bms_n, far_ack;
    logic req_ready, rsp_valid, slv_valid, slv_write, ext_address_lines_oe;
    logic ext_data_lines_oe, read_n_in, read_n_out, low_word_write_n_in;
    logic low_word_write_n_out, high_word_write_n_in, high_word_write_n_out;
    logic strobe_oe, consecutive_transfer_n_in, consecutive_transfer_n_out;
    logic ack_in, ack_out, ack_oe, host_space_select_n, select_oe;
    logic boot_memory_select_n_in, boot_memory_select_n_out;
    logic boot_memory_select_n_oe, eprom_boot_strap;
    logic [1:0]  slv_lanes, bank_select_n;
    logic [3:0]  waits;
    logic [31:0] req_addr, tb_addr, slv_addr, ext_address_lines_in;
    logic [31:0] ext_address_lines_out;
    logic [63:0] req_wdata, slv_rdata, tb_data, rsp_rdata, slv_wdata;
    logic [63:0] ext_data_lines_in, ext_data_lines_out, far_data;
    int          n_mismatch = 0;
    int          check_count = 0;
    ebc_external_bus_control ebc_external_bus_control_inst (.*);
    ebc_far_mem ebc_far_mem_inst (.clk, .rst_n, .strobe_oe, .read_n(read_n_out),
        .wr_n(low_word_write_n_out & high_word_write_n_out), .waits,
        .addr(ext_address_lines_out), .ack(far_ack), .data(far_data));
    // Pin levels from all drivers; ack is open drain
    assign ext_address_lines_in = ext_address_lines_oe ?
                                  ext_address_lines_out : tb_addr;
    assign ext_data_lines_in = ext_data_lines_oe ? ext_data_lines_out :
                               (bus_master ? far_data : tb_data);
    assign read_n_in = strobe_oe ? read_n_out : tb_rd_n;
    assign low_word_write_n_in = strobe_oe ? low_word_write_n_out : tb_wl_n;
    assign high_word_write_n_in = strobe_oe ? high_word_write_n_out : tb_wh_n;
    assign consecutive_transfer_n_in = strobe_oe ?
                                       consecutive_transfer_n_out : tb_burst_n;
    assign ack_in = far_ack & !ack_oe;
    assign boot_memory_select_n_in = boot_memory_select_n_oe ?
                                     boot_memory_select_n_out : tb_bms_n;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task chk(input string nm, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task step;
        @(posedge clk);
        #1;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Bounded waits end the run when they run out
    task tmo(input int n);
        if (n >= 40) begin
            n_mismatch++;
            $display("FAIL wait expected 1 seen 0");
            end_sim;
        end
    endtask
    task m(input logic [31:0] a, input logic w, l, z, s, input logic [3:0] ws);
        int n;
        int k;
        logic got;
        logic [2:0] sn;
        logic [35:0] sa;
        logic [63:0] sd;
        got = 1'b0;
        k = 0;
        sn = 3'h7;
        {waits, req_addr, req_write, req_long, req_zone32} = {ws, a, w, l, z};
        req_burst = l;
        {req_sdram, req_wdata, req_valid} = {s, a, ~a, 1'b1};
        for (n = 0; !req_ready && n < 40; n++) step;
        tmo(n);
        step;
        req_valid = 1'b0;
        for (n = 0; !rsp_valid && n < 40; n++) begin
            if (got) k++;
            if (strobe_oe && !got) begin
                got = 1'b1;
                sn = {read_n_out, low_word_write_n_out, high_word_write_n_out};
                sa = {consecutive_transfer_n_out, bank_select_n,
                      host_space_select_n, ext_address_lines_out};
                sd = ext_data_lines_out;
            end
            step;
        end
        tmo(n);
        chk("read strobe", sn[2], w || s);
        chk("low strobe", sn[1], !(w && (!a[0] || z || l)));
        chk("high strobe", sn[0], !(w && !z && (a[0] || l)));
        if (got) begin
            chk("bank", sa[34:33], {a[31:26] != 6'h03, a[31:26] != 6'h02});
            chk("host", sa[32], a[31:28] == 4'h0);
            chk("address", sa[31:0], a);
            chk("waits", k, ws);
            chk("burst flag", sa[35], !l);
            if (w) chk("write data", sd, {a, ~a});
        end
        chk("rsp data", rsp_rdata, w ? {a, ~a} : {~a, a});
        step;
    endtask
    task t_master;
        bus_master = 1'b1;
        m(32'h0800_0000, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        m(32'h0c00_0004, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3);
        m(32'h0000_0010, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
        m(32'h0800_0002, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1);
        m(32'h0800_0003, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
        m(32'h0c00_0005, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
        m(32'h0800_0007, 1'b1, 1'b0, 1'b1, 1'b0, 4'h2);
        m(32'h1000_0001, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        $display("test master done");
    endtask
    // Stalled burst write: both words held, second address counted
    task t_sw;
        int n;
        {bus_master, slv_ready, tb_addr} = {2'h0, 32'h0000_0040};
        step;
        tb_data = 64'h1111_2222_3333_4444;
        {tb_wl_n, tb_wh_n, tb_burst_n} = 3'h0;
        step;
        {tb_addr, tb_data} = {32'h0000_0099, ~tb_data};
        step;
        {tb_wl_n, tb_wh_n, tb_burst_n} = 3'h7;
        repeat (3) step;
        chk("no drive", strobe_oe | select_oe, 1'b0);
        chk("stall hold", slv_valid, 1'b1);
        slv_ready = 1'b1;
        for (int i = 0; i < 2; i++) begin
            for (n = 0; !slv_valid && n < 40; n++) step;
            tmo(n);
            chk("slv write", {slv_write, slv_lanes}, 3'h7);
            chk("slv addr", slv_addr, 32'h40 + i);
            chk("slv data", slv_wdata[63:48], i ? 16'heeee : 16'h1111);
            step;
        end
        chk("drained", slv_valid, 1'b0);
        $display("test slave write done");
    endtask
    task t_sr;
        int n;
        {tb_addr, tb_rd_n} = {32'h0000_0123, 1'b0};
        for (n = 0; !slv_valid && n < 40; n++) step;
        tmo(n);
        chk("slv read", {slv_write, slv_addr}, {1'b0, 32'h123});
        step;
        chk("ack wait", ack_oe, 1'b1);
        {slv_rdata, slv_rdata_valid} = {64'h0123_4567_89ab_cdef, 1'b1};
        step;
        slv_rdata_valid = 1'b0;
        for (n = 0; !ext_data_lines_oe && n < 40; n++) step;
        tmo(n);
        chk("read data", ext_data_lines_out, 64'h0123_4567_89ab_cdef);
        tb_rd_n = 1'b1;
        repeat (2) step;
        chk("ack free", ack_oe, 1'b0);
        $display("test slave read done");
    endtask
    initial begin
        {bus_master, boot_active, req_valid, req_write, req_long} = 5'h0;
        {req_zone32, req_sdram, req_burst, slv_rdata_valid} = 4'h0;
        {tb_rd_n, tb_wl_n, tb_wh_n, tb_burst_n, slv_ready} = 5'h1f;
        {req_addr, tb_addr, waits, rst_n, tb_bms_n} = 70'h0;
        {req_wdata, slv_rdata, tb_data} = 192'h0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) step;
        tb_bms_n = 1'b1;
        chk("strap", eprom_boot_strap, 1'b1);
        {bus_master, boot_active} = 2'h3;
        repeat (2) step;
        chk("boot sel", {boot_memory_select_n_oe, boot_memory_select_n_out}, 2'h2);
        boot_active = 1'b0;
        $display("test boot done");
        t_master;
        t_sw;
        t_sr;
        end_sim;
    end
endmodule // ebc_external_bus_control_bench
